/* pkg/serial_load_pkg.sv */
// Constants and types for the three-wire register load port
// What this block and its host do
// [R1] Shift data line into 32-bit shift register on each serial clock rising edge.
// [R2] On latch strobe rising edge, copy shift register into addressed control register.
// [R3] Host holds latch strobe low before and while shifting a word.
// [R4] Host sends each full 32-bit word, e.g. four 8-bit bytes.
// [R5] Host raises latch strobe after the last byte to finish the write.
// [R6] Host SPI master uses clock phase zero; data stable at rising edge.
// [R7] Status pin can show lock detect; host may poll it.
// [R8] Power-down input level puts the device into or out of power-down.
// [R9] Output power comes from bits two and one of control register four.
// [R10] Words arrive MSB first; low bits of the word select the register.
package serial_load_pkg;
    // ****************************************
    // Word layout
    // ****************************************
    localparam int WORD_BITS = 32;
    localparam int CTRL_BITS = 3;
    localparam int REG_COUNT = 6;
    localparam int PWR_REG_INDEX = 4;
    localparam int PWR_BIT_HIGH_POS = 2;
    localparam int PWR_BIT_LOW_POS = 1;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    // Status pin source selector, a three-bit field in register two
    localparam int MUX_LSB = 26;
    localparam int MUX_BITS = 3;
    localparam logic [2:0] MUX_LOW = 3'h0;
    localparam logic [2:0] MUX_HIGH = 3'h1;
    localparam logic [2:0] MUX_LOCK = 3'h6;
    localparam int MUX_REG_INDEX = 2;

    // Pins from the serial host, sampled into the system clock domain
    typedef struct packed {
        logic sclk;
        logic sdata;
        logic latch_strobe;
    } serial_pins_t;
    // Reset level of the pin stages; a strobe stage resting high cannot fake a latch edge
    localparam serial_pins_t PINS_RESET = '{sclk: 1'b0, sdata: 1'b0, latch_strobe: 1'b1};
endpackage : serial_load_pkg

/* src/three_wire_register_load.sv */
// Three-wire serial register load port with status and power-down outputs
module three_wire_register_load (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Serial pins from the host
    input wire serial_load_pkg::serial_pins_t pins,
    input wire logic power_down_pin,
    // Device state
    input wire logic pll_locked,
    output logic selectable_status_pin,
    output logic power_down,
    output logic output_power_bit_high,
    output logic output_power_bit_low,
    output logic [31:0] reg_view [serial_load_pkg::REG_COUNT]
);
    import serial_load_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    // Host pin synchroniser stages; edges are found between the last two
    serial_pins_t meta_r;
    serial_pins_t meta_nxt;
    serial_pins_t sync_r;
    serial_pins_t sync_nxt;
    serial_pins_t prev_r;
    serial_pins_t prev_nxt;
    // Power-down pin synchroniser stages
    logic pd_meta_r;
    logic pd_meta_nxt;
    logic pd_sync_r;
    logic pd_sync_nxt;
    // Word under assembly and the control registers it feeds
    logic [WORD_BITS-1:0] shift_r;
    logic [WORD_BITS-1:0] shift_nxt;
    logic [WORD_BITS-1:0] regs_r [REG_COUNT];
    logic [WORD_BITS-1:0] regs_nxt [REG_COUNT];
    // Next values of the registered outputs
    logic status_nxt;
    logic power_down_nxt;
    logic power_high_nxt;
    logic power_low_nxt;
    // Decoded events and the destination field of the word
    logic sclk_rise;
    logic strobe_rise;
    logic [CTRL_BITS-1:0] dest;

    // ****************************************
    // Decode helpers
    // ****************************************
    // Selector field of the status source, read by the output logic and its checks
    function automatic logic [MUX_BITS-1:0] status_code(input logic [WORD_BITS-1:0] word);
        return word[MUX_LSB +: MUX_BITS];
    endfunction : status_code

    // Only implemented registers may be written; other fields are dropped, not aliased
    function automatic logic index_valid(input logic [CTRL_BITS-1:0] idx);
        return int'(idx) < REG_COUNT;
    endfunction : index_valid

    // Level shown on the status pin for one selector code
    function automatic logic status_level(input logic [MUX_BITS-1:0] code, input logic locked);
        logic level;
        level = 1'b0;
        unique case (code)
            MUX_LOW: begin
                level = 1'b0;
            end
            MUX_HIGH: begin
                level = 1'b1;
            end
            MUX_LOCK: begin
                level = locked; // R7
            end
            // Unused codes drive low so a stray setting never fakes a lock
            default: begin
                level = 1'b0;
            end
        endcase
        return level;
    endfunction : status_level

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Two stages before any logic reads a pin; a third stage keeps the previous level
    always_comb begin
        meta_nxt = pins;
        sync_nxt = meta_r;
        prev_nxt = sync_r;
        pd_meta_nxt = power_down_pin;
        pd_sync_nxt = pd_meta_r;
    end

    // Strobe stages reset high, so a strobe still high at reset gives no false latch
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= PINS_RESET;
            sync_r <= PINS_RESET;
            prev_r <= PINS_RESET;
            pd_meta_r <= '0;
            pd_sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
            pd_meta_r <= pd_meta_nxt;
            pd_sync_r <= pd_sync_nxt;
        end
    end

    // Edge detection looks only at the second and third stages, never the metastable first
    assign sclk_rise = sync_r.sclk & ~prev_r.sclk;
    assign strobe_rise = sync_r.latch_strobe & ~prev_r.latch_strobe;
    assign dest = shift_r[CTRL_BITS-1:0]; // R10

    // ****************************************
    // Shift and latch
    // ****************************************
    // Serial clock is slow against sys_clk, so it is oversampled, not used as a clock
    always_comb begin
        shift_nxt = shift_r;
        regs_nxt = regs_r;
        if (sclk_rise) begin
            shift_nxt = {shift_r[WORD_BITS-2:0], sync_r.sdata}; // R1 R10
        end
        if (strobe_rise && index_valid(dest)) begin
            regs_nxt[dest] = shift_r; // R2 R10
        end
    end

    // Only registers the word under assembly and the control registers
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_r <= '0;
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_r[i] <= REG_RESET;
            end
        end else begin
            shift_r <= shift_nxt;
            regs_r <= regs_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Outputs follow settled register state one clock later, so they never glitch
    always_comb begin
        status_nxt = status_level(status_code(regs_r[MUX_REG_INDEX]), pll_locked); // R7
        power_down_nxt = pd_sync_r; // R8
        power_high_nxt = regs_r[PWR_REG_INDEX][PWR_BIT_HIGH_POS]; // R9
        power_low_nxt = regs_r[PWR_REG_INDEX][PWR_BIT_LOW_POS]; // R9
    end

    // Only registers the output levels
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            selectable_status_pin <= '0;
            power_down <= '0;
            output_power_bit_high <= '0;
            output_power_bit_low <= '0;
        end else begin
            selectable_status_pin <= status_nxt;
            power_down <= power_down_nxt;
            output_power_bit_high <= power_high_nxt;
            output_power_bit_low <= power_low_nxt;
        end
    end

    // Registers are shown directly; they already come from flip-flops
    assign reg_view = regs_r;

    // ****************************************
    // Checks
    // ****************************************
    // All checks sleep during reset and judge only what this block drives

    // A sampled serial edge shifts the synchronised data bit in at the bottom
    a_shift_in_bit: assert property (@(posedge sys_clk) disable iff (sys_rst) // R1
        sclk_rise |=> shift_r[0] == $past(sync_r.sdata))
        else $error("shift register missed serial bit");

    // Without a serial edge the word under assembly must not move
    a_hold_no_edge: assert property (@(posedge sys_clk) disable iff (sys_rst) // R1
        !sclk_rise |=> shift_r == $past(shift_r))
        else $error("shift register moved without clock edge");

    // A latch to the power register copies the whole assembled word
    a_latch_copies: assert property (@(posedge sys_clk) disable iff (sys_rst) // R2
        (strobe_rise && dest == PWR_REG_INDEX) |=> regs_r[PWR_REG_INDEX] == $past(shift_r))
        else $error("latch strobe did not load register");

    // A latch with an unimplemented index leaves the power register alone
    a_bad_index_kept: assert property (@(posedge sys_clk) disable iff (sys_rst) // R2
        (strobe_rise && !index_valid(dest)) |=>
            regs_r[PWR_REG_INDEX] == $past(regs_r[PWR_REG_INDEX]))
        else $error("bad index latch changed a register");

    // Power-down output goes high one clock after the synchronised input rises
    a_power_down_follows: assert property (@(posedge sys_clk) disable iff (sys_rst) // R8
        $rose(pd_sync_r) |=> power_down)
        else $error("power-down did not follow input");

    // Power-down output goes low one clock after the synchronised input falls
    a_power_up_follows: assert property (@(posedge sys_clk) disable iff (sys_rst) // R8
        $fell(pd_sync_r) |=> !power_down)
        else $error("power-down did not release");

    // Both power bits mirror the power register one clock later
    a_power_bits: assert property (@(posedge sys_clk) disable iff (sys_rst) // R9
        ##1 (output_power_bit_high == $past(regs_r[PWR_REG_INDEX][PWR_BIT_HIGH_POS])
            && output_power_bit_low == $past(regs_r[PWR_REG_INDEX][PWR_BIT_LOW_POS])))
        else $error("output power bit wrong");

    // Lock selection shows the lock level one clock later
    a_lock_status: assert property (@(posedge sys_clk) disable iff (sys_rst) // R7
        (status_code(regs_r[MUX_REG_INDEX]) == MUX_LOCK) |=>
            selectable_status_pin == $past(pll_locked))
        else $error("status pin not showing lock");

    // Fixed-high selection drives the status pin high
    a_status_high: assert property (@(posedge sys_clk) disable iff (sys_rst) // R7
        (status_code(regs_r[MUX_REG_INDEX]) == MUX_HIGH) |=> selectable_status_pin)
        else $error("status pin not high");

    // Fixed-low selection, the state after reset, drives the status pin low
    a_status_low: assert property (@(posedge sys_clk) disable iff (sys_rst) // R7
        (status_code(regs_r[MUX_REG_INDEX]) == MUX_LOW) |=> !selectable_status_pin)
        else $error("status pin not low");
endmodule : three_wire_register_load

/* verif/host_model.sv */
// Host model that shifts words into the load port
module host_model (
    // Serial pins toward the device
    output serial_load_pkg::serial_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pins = '0;
    // Three clocks per phase keeps sclk above its two-clock minimum
    task send_word(input logic [31:0] w);
        pins.latch_strobe = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            pins.sdata = w[i];
            #120 pins.sclk = 1'b1;
            #120 pins.sclk = 1'b0;
        end
        pins.sdata = ~w[0]; // Stale data is inverted, never left valid
        #120 pins.latch_strobe = 1'b1;
        #400;
    endtask : send_word
endmodule : host_model

/* verif/testbench.sv */
// Self-checking bench for the three-wire register load port
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import serial_load_pkg::*;
    logic sys_clk = 0, sys_rst = 1, power_down_pin = 0, pll_locked = 0;
    logic sel_pin, pd, pw_hi, pw_lo;
    logic [31:0] reg_view [REG_COUNT];
    serial_pins_t pins;
    int failures = 0, comparisons = 0;
    typedef struct {logic [31:0] w; logic [31:0] e;} row_t;
    row_t rows [6] = '{'{32'hA5C3_0F18, 32'hA5C3_0F18}, '{32'h1234_5679, 32'h1234_5679},
        '{32'h0400_0002, 32'h0400_0002}, '{32'h8765_432B, 32'h8765_432B},
        '{32'h8000_0004, 32'h8000_0004}, '{32'h0F0F_F0F5, 32'h0F0F_F0F5}};
    host_model host_u (.pins(pins));
    three_wire_register_load dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .pins(pins),
        .power_down_pin(power_down_pin), .pll_locked(pll_locked),
        .selectable_status_pin(sel_pin), .power_down(pd), .output_power_bit_high(pw_hi),
        .output_power_bit_low(pw_lo), .reg_view(reg_view));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task test_done;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    initial forever #20 sys_clk = ~sys_clk;
    // Watchdog sized well beyond ten words of traffic
    initial begin
        #200000;
        failures++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        #1 sys_rst = 0;
        for (int i = 0; i < REG_COUNT; i++) check(reg_view[i], REG_RESET);
        for (int i = 0; i < 6; i++) begin
            host_u.send_word(rows[i].w);
            check(reg_view[rows[i].w[2:0]], rows[i].e);
        end
        check(pw_hi, 1'b1);
        check(pw_lo, 1'b0);
        check(sel_pin, 1'b1);
        // Lock selection must track the lock level both ways
        host_u.send_word(32'h1800_0002);
        pll_locked = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 check(sel_pin, 1'b1);
        pll_locked = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 check(sel_pin, 1'b0);
        // Index six is out of range and must leave registers 0 and 5 alone
        host_u.send_word(32'hDEAD_BEE6);
        check(reg_view[0], rows[0].e);
        check(reg_view[5], rows[5].e);
        power_down_pin = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 check(pd, 1'b1);
        power_down_pin = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1 check(pd, 1'b0);
        // Reset in mid-run with the strobe left high: all returns to rest, no false latch
        sys_rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        repeat (6) @(posedge sys_clk);
        #1 check(pw_hi, 1'b0);
        check(sel_pin, 1'b0);
        for (int i = 0; i < REG_COUNT; i++) check(reg_view[i], REG_RESET);
        // The port takes a new word straight after the release
        host_u.send_word(32'h4000_0004);
        check(reg_view[PWR_REG_INDEX], 32'h4000_0004);
        check(pw_hi, 1'b1);
        test_done();
    end
endmodule : testbench
